// ==== efb_branch_unit.sv ====
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// - fifo-wrap jump taken when flag set
// - irq-pending jump taken when flag set
// - no-attention jump taken when flag clear
// - no-alarm-one jump taken when flag clear
// - no-alarm-two jump taken when flag clear
// - no-alarm-three jump taken when flag clear
// - no-fifo-wrap jump taken when flag clear
// - no-irq jump taken when flag clear
// - no-pin-match jump taken when flag clear
// - queue-filled jump taken when empty flag clear
// - queue-empty jump taken when flag set
// - selectable-one jump taken when flag set
// - no-selectable-two jump taken when flag clear
// - no-selectable-three jump taken when flag clear
// - no-selectable-four jump taken when flag clear
// - streamer-running jump taken when finished clear
// - command-pending jump taken when empty clear
// - local 2 or 4 clocks, shared 2 or more
module efb_branch_unit
   import efb_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic [7:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic INSN_VALID,
   output logic INSN_READY,
   input wire logic [OP_W-1:0] INSN_OP,
   input wire logic INSN_IMM_SEL,
   input wire logic [PC_W-1:0] INSN_IMM,
   input wire logic [PC_W-1:0] REG_S_VALUE,
   input wire logic [PC_W-1:0] PC_CUR,
   input wire logic EXEC_SHARED,
   input wire logic SHARED_FETCH_RDY,
   input wire logic FIFO_BLOCK_WRAP_FLAG,
   input wire logic IRQ_PENDING_FLAG,
   input wire logic ATTENTION_FLAG,
   input wire logic COUNTER_ALARM_ONE_FLAG,
   input wire logic COUNTER_ALARM_TWO_FLAG,
   input wire logic COUNTER_ALARM_THREE_FLAG,
   input wire logic PIN_MATCH_FLAG,
   input wire logic RESULT_QUEUE_EMPTY_FLAG,
   input wire logic SELECTABLE_EVENT_ONE_FLAG,
   input wire logic SELECTABLE_EVENT_TWO_FLAG,
   input wire logic SELECTABLE_EVENT_THREE_FLAG,
   input wire logic SELECTABLE_EVENT_FOUR_FLAG,
   input wire logic STREAMER_FINISHED_FLAG,
   input wire logic STREAMER_COMMAND_EMPTY_FLAG,
   output logic DONE,
   output logic TAKEN,
   output logic ILLEGAL,
   output logic [PC_W-1:0] PC_NEXT
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   efb_cond_if cif ();
   efb_state_e state_r;
   efb_state_e state_nxt;
   logic [CNT_W-1:0] cyc_cnt_r;
   logic [CNT_W-1:0] cyc_cnt_nxt;
   logic [FLAG_W-1:0] flags;
   logic issue;
   logic finish;
   logic met_r;
   logic legal_r;
   logic shared_r;
   logic [PC_W-1:0] target_r;
   logic [PC_W-1:0] seq_pc_r;
   logic enable_r;
   logic clear_req;
   logic last_taken_r;
   logic last_illegal_r;
   logic last_shared_r;
   logic [STAT_W-1:0] taken_cnt_r;
   logic [STAT_W-1:0] fall_cnt_r;
   logic [PC_W-1:0] last_pc_r;
   logic apb_setup;
   logic apb_write;
   logic addr_hit;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // Flag gathering
   // ---------------------------------------------------------------
   always_comb
   begin
      flags = '0;
      flags[FL_FIFO_WRAP] = FIFO_BLOCK_WRAP_FLAG;
      flags[FL_IRQ] = IRQ_PENDING_FLAG;
      flags[FL_ATTENTION] = ATTENTION_FLAG;
      flags[FL_ALARM_ONE] = COUNTER_ALARM_ONE_FLAG;
      flags[FL_ALARM_TWO] = COUNTER_ALARM_TWO_FLAG;
      flags[FL_ALARM_THREE] = COUNTER_ALARM_THREE_FLAG;
      flags[FL_PIN_MATCH] = PIN_MATCH_FLAG;
      flags[FL_QUEUE_EMPTY] = RESULT_QUEUE_EMPTY_FLAG;
      flags[FL_SEL_ONE] = SELECTABLE_EVENT_ONE_FLAG;
      flags[FL_SEL_TWO] = SELECTABLE_EVENT_TWO_FLAG;
      flags[FL_SEL_THREE] = SELECTABLE_EVENT_THREE_FLAG;
      flags[FL_SEL_FOUR] = SELECTABLE_EVENT_FOUR_FLAG;
      flags[FL_STRM_DONE] = STREAMER_FINISHED_FLAG;
      flags[FL_STRM_CMD_EMPTY] = STREAMER_COMMAND_EMPTY_FLAG;
   end

   // ---------------------------------------------------------------
   // Condition evaluation
   // ---------------------------------------------------------------
   assign cif.flags = flags;
   assign cif.op = INSN_OP;

   // Set or clear test per operation
   // Set or clear test per operation
   efb_cond_eval u_eval
   (
      .cif (cif.eval)
   );

   // ---------------------------------------------------------------
   // Issue handshake
   // ---------------------------------------------------------------
   assign INSN_READY = (state_r == ST_IDLE) && enable_r;
   assign issue = INSN_VALID && INSN_READY;

   // ---------------------------------------------------------------
   // Operand capture
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         met_r <= 1'b0;
         legal_r <= 1'b0;
         shared_r <= 1'b0;
         target_r <= '0;
         seq_pc_r <= '0;
      end
      else if (issue)
      begin
         met_r <= cif.met;
         legal_r <= cif.legal;
         shared_r <= EXEC_SHARED;
         target_r <= INSN_IMM_SEL ? INSN_IMM : REG_S_VALUE;
         seq_pc_r <= PC_W'(PC_CUR + 1'b1);
      end
   end

   // ---------------------------------------------------------------
   // Execution sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cyc_cnt_nxt = cyc_cnt_r;
      finish = 1'b0;
      unique case (state_r)
         ST_IDLE:
         begin
            cyc_cnt_nxt = '0;
            if (issue)
            begin
               state_nxt = ST_EVAL;
               cyc_cnt_nxt = 5'h01;
            end
         end
         ST_EVAL:
         begin
            // Not taken: 2 clocks in both modes
            if (!met_r || !legal_r)
            begin
               finish = 1'b1;
            end
            else
            begin
               state_nxt = shared_r ? ST_SHARED_REFILL : ST_LOCAL_REFILL;
               cyc_cnt_nxt = CNT_W'(cyc_cnt_r + 1'b1);
            end
         end
         ST_LOCAL_REFILL:
         begin
            // Taken locally: 4 clocks
            if (cyc_cnt_r == LOCAL_TAKEN_CYC - 5'h01)
            begin
               finish = 1'b1;
            end
            else
            begin
               cyc_cnt_nxt = CNT_W'(cyc_cnt_r + 1'b1);
            end
         end
         ST_SHARED_REFILL:
         begin
            // Taken from shared memory: fetch-paced, bounded
            if ((cyc_cnt_r >= SHARED_TAKEN_MIN_CYC - 5'h01 && SHARED_FETCH_RDY)
               || cyc_cnt_r == SHARED_TAKEN_MAX_CYC - 5'h01)
            begin
               finish = 1'b1;
            end
            else
            begin
               cyc_cnt_nxt = CNT_W'(cyc_cnt_r + 1'b1);
            end
         end
      endcase
      if (finish)
      begin
         state_nxt = ST_IDLE;
         cyc_cnt_nxt = '0;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         state_r <= ST_IDLE;
         cyc_cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Completion outputs
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         DONE <= 1'b0;
         TAKEN <= 1'b0;
         ILLEGAL <= 1'b0;
         PC_NEXT <= '0;
      end
      else
      begin
         DONE <= finish;
         TAKEN <= finish && met_r && legal_r;
         ILLEGAL <= finish && !legal_r;
         if (finish)
         begin
            // Redirect or fall through
            PC_NEXT <= (met_r && legal_r) ? target_r : seq_pc_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status tracking
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         last_taken_r <= 1'b0;
         last_illegal_r <= 1'b0;
         last_shared_r <= 1'b0;
         last_pc_r <= '0;
      end
      else if (finish)
      begin
         last_taken_r <= met_r && legal_r;
         last_illegal_r <= !legal_r;
         last_shared_r <= shared_r;
         last_pc_r <= (met_r && legal_r) ? target_r : seq_pc_r;
      end
   end

   // A count in the same cycle as a clear loads the counter with one
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         taken_cnt_r <= '0;
         fall_cnt_r <= '0;
      end
      else
      begin
         if (finish && met_r && legal_r)
         begin
            taken_cnt_r <= clear_req ? 16'h0001 : STAT_W'(taken_cnt_r + 1'b1);
         end
         else if (clear_req)
         begin
            taken_cnt_r <= '0;
         end
         if (finish && !(met_r && legal_r))
         begin
            fall_cnt_r <= clear_req ? 16'h0001 : STAT_W'(fall_cnt_r + 1'b1);
         end
         else if (clear_req)
         begin
            fall_cnt_r <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign PREADY = 1'b1;
   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PWRITE;
   assign addr_hit = (PADDR == REG_CTRL) || (PADDR == REG_STATUS)
      || (PADDR == REG_TAKEN_CNT) || (PADDR == REG_FALL_CNT)
      || (PADDR == REG_LAST_PC) || (PADDR == REG_FLAGS);
   assign clear_req = apb_write && PADDR == REG_CTRL && PSTRB[0] && PWDATA[CTRL_CLEAR_BIT];

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         enable_r <= CTRL_ENABLE_RST;
      end
      else if (apb_write && PADDR == REG_CTRL && PSTRB[0])
      begin
         enable_r <= PWDATA[CTRL_ENABLE_BIT];
      end
   end

   always_comb
   begin
      rd_mux = '0;
      unique case (PADDR)
         REG_CTRL: rd_mux[CTRL_ENABLE_BIT] = enable_r;
         REG_STATUS: rd_mux[3:0] = {last_shared_r, last_illegal_r, last_taken_r,
            state_r != ST_IDLE};
         REG_TAKEN_CNT: rd_mux[STAT_W-1:0] = taken_cnt_r;
         REG_FALL_CNT: rd_mux[STAT_W-1:0] = fall_cnt_r;
         REG_LAST_PC: rd_mux[PC_W-1:0] = last_pc_r;
         REG_FLAGS: rd_mux[FLAG_W-1:0] = flags;
         default: rd_mux = '0;
      endcase
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end
      else if (apb_setup)
      begin
         PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
         PSLVERR <= !addr_hit;
      end
      else if (!PSEL)
      begin
         PSLVERR <= 1'b0;
      end
   end

endmodule : efb_branch_unit

// ==== efb_pkg.sv ====
package efb_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int FLAG_W = 14;
   localparam int OP_W = 5;
   localparam int PC_W = 20;
   localparam int CNT_W = 5;
   localparam int STAT_W = 16;

   // ---------------------------------------------------------------
   // Event flag positions
   // ---------------------------------------------------------------
   localparam logic [3:0] FL_FIFO_WRAP = 4'h0;
   localparam logic [3:0] FL_IRQ = 4'h1;
   localparam logic [3:0] FL_ATTENTION = 4'h2;
   localparam logic [3:0] FL_ALARM_ONE = 4'h3;
   localparam logic [3:0] FL_ALARM_TWO = 4'h4;
   localparam logic [3:0] FL_ALARM_THREE = 4'h5;
   localparam logic [3:0] FL_PIN_MATCH = 4'h6;
   localparam logic [3:0] FL_QUEUE_EMPTY = 4'h7;
   localparam logic [3:0] FL_SEL_ONE = 4'h8;
   localparam logic [3:0] FL_SEL_TWO = 4'h9;
   localparam logic [3:0] FL_SEL_THREE = 4'hA;
   localparam logic [3:0] FL_SEL_FOUR = 4'hB;
   localparam logic [3:0] FL_STRM_DONE = 4'hC;
   localparam logic [3:0] FL_STRM_CMD_EMPTY = 4'hD;

   // ---------------------------------------------------------------
   // Jump operation codes
   // ---------------------------------------------------------------
   localparam logic [OP_W-1:0] OP_JUMP_IF_FIFO_WRAP = 5'h00;
   localparam logic [OP_W-1:0] OP_JUMP_IF_IRQ_PENDING = 5'h01;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_ATTENTION = 5'h02;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_ALARM_ONE = 5'h03;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_ALARM_TWO = 5'h04;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_ALARM_THREE = 5'h05;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_FIFO_WRAP = 5'h06;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_IRQ_PENDING = 5'h07;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_PIN_MATCH = 5'h08;
   localparam logic [OP_W-1:0] OP_JUMP_IF_RESULT_QUEUE_FILLED = 5'h09;
   localparam logic [OP_W-1:0] OP_JUMP_IF_RESULT_QUEUE_EMPTY = 5'h0A;
   localparam logic [OP_W-1:0] OP_JUMP_IF_SEL_EVENT_ONE = 5'h0B;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_SEL_EVENT_TWO = 5'h0C;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_SEL_EVENT_THREE = 5'h0D;
   localparam logic [OP_W-1:0] OP_JUMP_IF_NO_SEL_EVENT_FOUR = 5'h0E;
   localparam logic [OP_W-1:0] OP_JUMP_IF_STREAMER_RUNNING = 5'h0F;
   localparam logic [OP_W-1:0] OP_JUMP_IF_STREAMER_CMD_PENDING = 5'h10;

   // ---------------------------------------------------------------
   // Cycle costs
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] LOCAL_NOT_TAKEN_CYC = 5'h02;
   localparam logic [CNT_W-1:0] LOCAL_TAKEN_CYC = 5'h04;
   localparam logic [CNT_W-1:0] SHARED_NOT_TAKEN_CYC = 5'h02;
   localparam logic [CNT_W-1:0] SHARED_TAKEN_MIN_CYC = 5'h0D;
   localparam logic [CNT_W-1:0] SHARED_TAKEN_MAX_CYC = 5'h14;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
   localparam logic [7:0] REG_FALL_CNT = 8'h0C;
   localparam logic [7:0] REG_LAST_PC = 8'h10;
   localparam logic [7:0] REG_FLAGS = 8'h14;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam logic CTRL_ENABLE_RST = 1'b1;

   // Decode: {legal, branch when set, flag index}
   function automatic logic [5:0] op_decode(input logic [OP_W-1:0] op);
      logic [5:0] d;
      d = 6'h00;
      unique case (op)
         OP_JUMP_IF_FIFO_WRAP: d = {2'b11, FL_FIFO_WRAP};
         OP_JUMP_IF_IRQ_PENDING: d = {2'b11, FL_IRQ};
         OP_JUMP_IF_NO_ATTENTION: d = {2'b10, FL_ATTENTION};
         OP_JUMP_IF_NO_ALARM_ONE: d = {2'b10, FL_ALARM_ONE};
         OP_JUMP_IF_NO_ALARM_TWO: d = {2'b10, FL_ALARM_TWO};
         OP_JUMP_IF_NO_ALARM_THREE: d = {2'b10, FL_ALARM_THREE};
         OP_JUMP_IF_NO_FIFO_WRAP: d = {2'b10, FL_FIFO_WRAP};
         OP_JUMP_IF_NO_IRQ_PENDING: d = {2'b10, FL_IRQ};
         OP_JUMP_IF_NO_PIN_MATCH: d = {2'b10, FL_PIN_MATCH};
         OP_JUMP_IF_RESULT_QUEUE_FILLED: d = {2'b10, FL_QUEUE_EMPTY};
         OP_JUMP_IF_RESULT_QUEUE_EMPTY: d = {2'b11, FL_QUEUE_EMPTY};
         OP_JUMP_IF_SEL_EVENT_ONE: d = {2'b11, FL_SEL_ONE};
         OP_JUMP_IF_NO_SEL_EVENT_TWO: d = {2'b10, FL_SEL_TWO};
         OP_JUMP_IF_NO_SEL_EVENT_THREE: d = {2'b10, FL_SEL_THREE};
         OP_JUMP_IF_NO_SEL_EVENT_FOUR: d = {2'b10, FL_SEL_FOUR};
         OP_JUMP_IF_STREAMER_RUNNING: d = {2'b10, FL_STRM_DONE};
         OP_JUMP_IF_STREAMER_CMD_PENDING: d = {2'b10, FL_STRM_CMD_EMPTY};
         default: d = 6'h00;
      endcase
      return d;
   endfunction : op_decode

   typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_LOCAL_REFILL, ST_SHARED_REFILL} efb_state_e;

endpackage : efb_pkg

// ==== efb_cond_if.sv ====
`timescale 1ns/1ps
interface efb_cond_if;
   import efb_pkg::*;
   logic [FLAG_W-1:0] flags;
   logic [OP_W-1:0] op;
   logic met;
   logic legal;
   modport src (output flags, output op, input met, input legal);
   modport eval (input flags, input op, output met, output legal);
endinterface : efb_cond_if

// ==== efb_cond_eval.sv ====
`timescale 1ns/1ps
module efb_cond_eval
   import efb_pkg::*;
(
   efb_cond_if.eval cif
);

   // ---------------------------------------------------------------
   // Flag test
   // ---------------------------------------------------------------
   logic [5:0] dec;
   logic flag_sel;

   always_comb
   begin
      dec = op_decode(cif.op);
      flag_sel = cif.flags[dec[3:0]];
   end

   // Set or clear polarity per operation
   assign cif.legal = dec[5];
   assign cif.met = dec[5] & (flag_sel == dec[4]);

endmodule : efb_cond_eval

// ==== efb_branch_unit_sva.sv ====
`timescale 1ns/1ps
// ----------------
// Branch timing checker
// ----------------
module efb_branch_unit_sva
   import efb_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic INSN_VALID,
   input wire logic INSN_READY,
   input wire logic INSN_IMM_SEL,
   input wire logic [PC_W-1:0] INSN_IMM,
   input wire logic [PC_W-1:0] REG_S_VALUE,
   input wire logic [PC_W-1:0] PC_CUR,
   input wire logic EXEC_SHARED,
   input wire logic SHARED_FETCH_RDY,
   input wire logic DONE,
   input wire logic TAKEN,
   input wire logic ILLEGAL,
   input wire logic [PC_W-1:0] PC_NEXT
);
   logic issue;
   logic busy_r;
   logic sh_r;
   logic [CNT_W-1:0] cnt_r;
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] tgt_r;

   assign issue = INSN_VALID && INSN_READY;

   // Cycles since issue
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         busy_r <= 1'b0;
         cnt_r <= 5'h00;
      end
      else if (issue)
      begin
         busy_r <= 1'b1;
         cnt_r <= 5'h01;
      end
      else if (DONE)
         busy_r <= 1'b0;
      else if (busy_r)
         cnt_r <= cnt_r + 5'h01;
   end

   // Operands held from issue
   always_ff @(posedge SYS_CLK)
   begin
      if (issue)
      begin
         pc_r <= PC_CUR;
         tgt_r <= INSN_IMM_SEL ? INSN_IMM : REG_S_VALUE;
         sh_r <= EXEC_SHARED;
      end
   end

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   a_fall_two_clk: assert property (DONE && !TAKEN |-> cnt_r == 5'h02)
      else $error("fall-through not in 2 clocks");
   a_local_four_clk: assert property (DONE && TAKEN && !sh_r |-> cnt_r == 5'h04)
      else $error("local taken jump not in 4 clocks");
   a_shared_range: assert property (DONE && TAKEN && sh_r |-> cnt_r inside {[5'h0D:5'h14]})
      else $error("shared taken jump outside 13 to 20 clocks");
   a_fetch_pace: assert property (busy_r && sh_r && !DONE && SHARED_FETCH_RDY
      && cnt_r >= 5'h0C |=> DONE) else $error("shared refetch ready but no completion");
   a_issue_bound: assert property (issue |-> ##[2:20] DONE)
      else $error("instruction never completed");
   a_busy_refuse: assert property (issue |=> !INSN_READY)
      else $error("new instruction accepted while busy");
   a_fall_target: assert property (DONE && !TAKEN |-> PC_NEXT == pc_r + 20'h00001)
      else $error("fall-through address wrong");
   a_jump_target: assert property (DONE && TAKEN |-> PC_NEXT == tgt_r)
      else $error("branch target wrong");
   a_pc_hold: assert property (!DONE |-> $stable(PC_NEXT))
      else $error("next address moved without completion");
   a_illegal_falls: assert property (ILLEGAL |-> DONE && !TAKEN)
      else $error("illegal code not a plain fall-through");
endmodule : efb_branch_unit_sva

// ==== efb_branch_unit_tb_top.sv ====
`timescale 1ns/1ps
module efb_branch_unit_tb_top;
   import efb_pkg::*;
   // ----------------
   // Stimulus and results
   // ----------------
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic insn_valid = 1'b0;
   logic [OP_W-1:0] insn_op = 5'h00;
   logic insn_imm_sel = 1'b0;
   logic [PC_W-1:0] insn_imm = 20'h00000;
   logic [PC_W-1:0] reg_s_value = 20'h00000;
   logic [PC_W-1:0] pc_cur = 20'h00000;
   logic exec_shared = 1'b0;
   logic fetch_rdy = 1'b0;
   logic [FLAG_W-1:0] flags = 14'h0000;
   logic [31:0] prdata;
   logic pready, pslverr, insn_ready, done, taken, illegal;
   logic [PC_W-1:0] pc_next;
   logic [31:0] rd;
   logic er;
   int error_cnt = 0;
   int n_compared = 0;
   localparam logic [16:0] SET_POL = 17'h00C03;
   localparam logic [3:0] FIDX [17] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0, 4'h1, 4'h6,
      4'h7, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};

   initial forever #12.5 sys_clk = ~sys_clk;

   efb_branch_unit dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .PADDR(paddr), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .INSN_VALID(insn_valid), .INSN_READY(insn_ready),
      .INSN_OP(insn_op), .INSN_IMM_SEL(insn_imm_sel), .INSN_IMM(insn_imm),
      .REG_S_VALUE(reg_s_value), .PC_CUR(pc_cur), .EXEC_SHARED(exec_shared),
      .SHARED_FETCH_RDY(fetch_rdy), .FIFO_BLOCK_WRAP_FLAG(flags[0]), .IRQ_PENDING_FLAG(flags[1]),
      .ATTENTION_FLAG(flags[2]), .COUNTER_ALARM_ONE_FLAG(flags[3]),
      .COUNTER_ALARM_TWO_FLAG(flags[4]), .COUNTER_ALARM_THREE_FLAG(flags[5]),
      .PIN_MATCH_FLAG(flags[6]), .RESULT_QUEUE_EMPTY_FLAG(flags[7]),
      .SELECTABLE_EVENT_ONE_FLAG(flags[8]), .SELECTABLE_EVENT_TWO_FLAG(flags[9]),
      .SELECTABLE_EVENT_THREE_FLAG(flags[10]), .SELECTABLE_EVENT_FOUR_FLAG(flags[11]),
      .STREAMER_FINISHED_FLAG(flags[12]), .STREAMER_COMMAND_EMPTY_FLAG(flags[13]),
      .DONE(done), .TAKEN(taken), .ILLEGAL(illegal), .PC_NEXT(pc_next));

   // ----------------
   // Shared tasks
   // ----------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic jump(input logic [4:0] op, input logic [13:0] fl, input logic sel,
      input logic sh, input int rdy_at, input logic [19:0] pc, input logic tk, input int sh_n);
      int n;
      logic [19:0] exp_pc;
      exp_pc = tk ? (sel ? 20'hA0000 | 20'(op) : 20'h50000 | 20'(op)) : pc + 20'h00001;
      @(posedge sys_clk);
      insn_valid <= 1'b1;
      insn_op <= op;
      flags <= fl;
      insn_imm_sel <= sel;
      insn_imm <= 20'hA0000 | 20'(op);
      reg_s_value <= 20'h50000 | 20'(op);
      pc_cur <= pc;
      exec_shared <= sh;
      fetch_rdy <= 1'b0;
      @(posedge sys_clk);
      insn_valid <= 1'b0;
      flags <= ~fl;
      n = 1;
      do
      begin
         @(posedge sys_clk);
         n++;
         fetch_rdy <= (n >= rdy_at);
         @(negedge sys_clk);
      end
      while (done !== 1'b1 && n < 40);
      chk(32'(n), tk ? (sh ? 32'(sh_n) : 32'h4) : 32'h2, "instruction clocks");
      chk(32'(taken), 32'(tk), "taken");
      chk(pc_next, exp_pc, "next address");
      chk(32'(illegal), 32'(op > 5'h10), "illegal");
   endtask : jump

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_reset;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1, "control reset");
      apb(1'b0, REG_TAKEN_CNT, 32'h0);
      chk(rd, 32'h0, "taken count reset");
      apb(1'b0, REG_LAST_PC, 32'h0);
      chk(rd, 32'h0, "last address reset");
      chk(32'(pready), 32'h1, "no wait states");
      $display("test reset done");
   endtask : t_reset

   task automatic t_flag_ops;
      logic [13:0] fl;
      for (int op = 0; op < 17; op++)
         for (int v = 0; v < 2; v++)
         begin
            fl = v[0] ? (14'h0001 << FIDX[op]) : ~(14'h0001 << FIDX[op]);
            jump(5'(op), fl, v[0], 1'b0, 0, 20'h01000 + 20'(op), v[0] == SET_POL[op], 0);
         end
      $display("test flag jumps done");
   endtask : t_flag_ops

   task automatic t_counters;
      apb(1'b0, REG_TAKEN_CNT, 32'h0);
      chk(rd, 32'h11, "taken count");
      apb(1'b0, REG_FALL_CNT, 32'h0);
      chk(rd, 32'h11, "fall count");
      apb(1'b0, REG_LAST_PC, 32'h0);
      chk(rd, 32'h01011, "last address");
      apb(1'b1, REG_CTRL, 32'h3);
      apb(1'b0, REG_TAKEN_CNT, 32'h0);
      chk(rd, 32'h0, "taken count cleared");
      apb(1'b0, REG_FALL_CNT, 32'h0);
      chk(rd, 32'h0, "fall count cleared");
      $display("test counters done");
   endtask : t_counters

   task automatic t_shared;
      jump(OP_JUMP_IF_FIFO_WRAP, 14'h0001, 1'b1, 1'b1, 12, 20'h02000, 1'b1, 13);
      jump(OP_JUMP_IF_FIFO_WRAP, 14'h0001, 1'b0, 1'b1, 99, 20'h02000, 1'b1, 20);
      jump(OP_JUMP_IF_FIFO_WRAP, 14'h3FFE, 1'b1, 1'b1, 0, 20'h02000, 1'b0, 0);
      $display("test shared done");
   endtask : t_shared

   task automatic t_illegal_wrap;
      jump(5'h1F, 14'h3FFF, 1'b1, 1'b0, 0, 20'hFFFFF, 1'b0, 0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h4, "status after illegal code");
      jump(OP_JUMP_IF_NO_ATTENTION, 14'h0004, 1'b1, 1'b0, 0, 20'hFFFFF, 1'b0, 0);
      apb(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h3FFB, "live flags");
      $display("test illegal done");
   endtask : t_illegal_wrap

   task automatic t_disable;
      apb(1'b1, REG_CTRL, 32'h0);
      @(negedge sys_clk);
      chk(32'(insn_ready), 32'h0, "ready while disabled");
      apb(1'b0, 8'h18, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped read");
      apb(1'b1, REG_CTRL, 32'h1);
      @(negedge sys_clk);
      chk(32'(insn_ready), 32'h1, "ready after enable");
      $display("test disable done");
   endtask : t_disable

   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_flag_ops();
      t_counters();
      t_shared();
      t_illegal_wrap();
      t_disable();
      conclude();
   end

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
endmodule : efb_branch_unit_tb_top

bind efb_branch_unit efb_branch_unit_sva u_sva (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
   .INSN_VALID(INSN_VALID), .INSN_READY(INSN_READY), .INSN_IMM_SEL(INSN_IMM_SEL),
   .INSN_IMM(INSN_IMM), .REG_S_VALUE(REG_S_VALUE), .PC_CUR(PC_CUR), .EXEC_SHARED(EXEC_SHARED),
   .SHARED_FETCH_RDY(SHARED_FETCH_RDY), .DONE(DONE), .TAKEN(TAKEN), .ILLEGAL(ILLEGAL),
   .PC_NEXT(PC_NEXT));
